/* common/nvm_prog_pkg.sv */
// constants, carriers and state layout for the nonvolatile programming control block
package nvm_prog_pkg;

    // ------------------------------------------------------------
    // register map (printed offsets are indices, byte address = 4 x index)
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_IDX = 12'h0007;
    localparam logic [11:0] OPT_IDX = 12'h0100;
    localparam logic [11:0] FACT_IDX = 12'h0110;
    localparam logic [11:0] STAT_IDX = 12'h0111;
    localparam logic [11:0] CTRL_ADDR = 12'h001c;
    localparam logic [11:0] OPT_ADDR = 12'h0400;
    localparam logic [11:0] FACT_ADDR = 12'h0440;
    localparam logic [11:0] STAT_ADDR = 12'h0444;

    // control register fields
    localparam int CTRL_EPROM_LAT = 5;
    localparam int CTRL_EPROM_PGM = 4;
    localparam int CTRL_EXT_CLOCK_OUT_EN = 3;
    localparam int CTRL_EE_ERA = 2;
    localparam int CTRL_EE_LAT = 1;
    localparam int CTRL_EE_PUMP = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // option byte fields
    localparam int OPT_UNPROT = 1;
    localparam int OPT_SEC_OFF = 0;

    // factory option byte fields
    localparam int FACT_POR_HOLD = 4;
    localparam int FACT_WDOG_RST = 3;
    localparam int FACT_WDOG_WAIT = 2;
    localparam int FACT_PB_PD = 1;
    localparam int FACT_PC_PD = 0;

    // status register fields
    localparam int STAT_EE_FAIL = 0;
    localparam int STAT_EP_GROUP_ERR = 1;

    // memory ranges on the cpu memory side
    localparam logic [15:0] EPROM_LO = 16'h0200;
    localparam logic [15:0] EPROM_HI = 16'h3dff;
    localparam logic [15:0] EEPROM_LO = 16'h0100;
    localparam logic [15:0] EEPROM_HI = 16'h01ff;
    localparam logic [15:0] EEPROM_UPPER = 16'h0120;

    // power-on reset pin hold, in cpu cycles
    localparam logic [11:0] POR_HOLD_SHORT = 12'h0010;
    localparam logic [11:0] POR_HOLD_LONG = 12'h0fe0;

    localparam int GROUP_BYTES = 8;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [7:0] data;
    } mem_wr_s;

    typedef struct packed {
        logic eprom_latch_en;
        logic eprom_prog_en;
        logic ext_clock_out_en;
        logic eeprom_erase_sel;
        logic eeprom_latch_en;
        logic eeprom_pump_en;
    } ctrl_s;

    typedef struct packed {
        ctrl_s ctrl;
        logic ep_have_byte;
        logic [12:0] ep_group;
        logic [GROUP_BYTES-1:0] ep_mask;
        logic [GROUP_BYTES-1:0][7:0] ep_data;
        logic ep_group_err;
        logic ee_addr_taken;
        logic [7:0] ee_addr;
        logic [7:0] ee_data;
        logic ee_fail;
        logic [7:0] opt_image;
        logic [7:0] fact_image;
        logic unprot_eff;
        logic sec_off_eff;
        logic opts_loaded;
        logic [11:0] por_cnt;
        logic por_hold_n;
        logic wdog_en;
        logic wdog_run;
        logic [7:0] portb_pd;
        logic [7:0] portc_pd;
        logic ee_pump_out;
        logic waitreq;
        logic [31:0] rdata;
    } state_s;

endpackage

/* src/nvm_prog_ctrl.sv */
// programming control for the on-chip eprom and eeprom with option bytes
`timescale 1ns/10ps

module nvm_prog_ctrl (
    input wire logic sys_clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // cpu memory write port
    input nvm_prog_pkg::mem_wr_s mem_wr,
    // system inputs
    input wire logic stop_entry,
    input wire logic wait_mode,
    input wire logic bootstrap_mode,
    input wire logic [7:0] factory_opt_in,
    input wire logic [7:0] option_nv_in,
    input wire logic [7:0] portb_ddr,
    input wire logic [7:0] portc_ddr,
    // eprom array side
    output logic eprom_read_ok,
    output logic eprom_prog_en,
    output logic [12:0] eprom_group_addr,
    output logic [7:0] eprom_byte_mask,
    output logic [63:0] eprom_group_data,
    // eeprom array side
    output logic eeprom_read_ok,
    output logic eeprom_erase_sel,
    output logic eeprom_pump_on,
    output logic [7:0] eeprom_addr,
    output logic [7:0] eeprom_data,
    // option effects
    output logic ext_clock_out_en,
    output logic por_hold_n,
    output logic wdog_enable,
    output logic wdog_running,
    output logic [7:0] portb_pulldown,
    output logic [7:0] portc_pulldown,
    output logic nonuser_mode_ok
);

    nvm_prog_pkg::state_s st_r;
    nvm_prog_pkg::state_s st_nxt;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    logic req;
    logic bus_take;
    logic wr_take;
    logic in_eprom;
    logic in_eeprom;
    logic ee_upper;
    logic ee_allowed;
    logic [7:0] ctrl_rd;
    logic [7:0] wd;

    // a request completes at the edge where waitrequest is seen low
    assign req = avs_read | avs_write;
    assign bus_take = req & ~st_r.waitreq;
    assign wr_take = bus_take & avs_write & avs_byteenable[0];
    assign wd = avs_writedata[7:0];
    assign in_eprom = (mem_wr.addr >= nvm_prog_pkg::EPROM_LO)
        && (mem_wr.addr <= nvm_prog_pkg::EPROM_HI);
    assign in_eeprom = (mem_wr.addr >= nvm_prog_pkg::EEPROM_LO)
        && (mem_wr.addr <= nvm_prog_pkg::EEPROM_HI);
    assign ee_upper = ({8'h01, st_r.ee_addr} >= nvm_prog_pkg::EEPROM_UPPER);
    // bootstrap lifts protection; lower part is never protected
    assign ee_allowed = ~ee_upper | st_r.unprot_eff | bootstrap_mode;

    // control readback, bits 7:6 are not implemented
    assign ctrl_rd = {2'b00, st_r.ctrl.eprom_latch_en, st_r.ctrl.eprom_prog_en,
        st_r.ctrl.ext_clock_out_en, st_r.ctrl.eeprom_erase_sel,
        st_r.ctrl.eeprom_latch_en, st_r.ctrl.eeprom_pump_en};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;

        // bus handshake: one wait cycle, then a single low cycle
        st_nxt.waitreq = ~(req & st_r.waitreq);
        if (req & st_r.waitreq) begin
            case (avs_address)
                nvm_prog_pkg::CTRL_ADDR: st_nxt.rdata = {24'h00_0000, ctrl_rd};
                nvm_prog_pkg::OPT_ADDR: st_nxt.rdata = {24'h00_0000, st_r.opt_image};
                nvm_prog_pkg::FACT_ADDR: st_nxt.rdata = {24'h00_0000, st_r.fact_image};
                nvm_prog_pkg::STAT_ADDR: st_nxt.rdata = {30'h0000_0000,
                    st_r.ep_group_err, st_r.ee_fail};
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // control register write
        if (wr_take && (avs_address == nvm_prog_pkg::CTRL_ADDR)) begin
            st_nxt.ctrl.eprom_latch_en = wd[nvm_prog_pkg::CTRL_EPROM_LAT];
            st_nxt.ctrl.ext_clock_out_en = wd[nvm_prog_pkg::CTRL_EXT_CLOCK_OUT_EN];
            // program enable: set needs latch already up and a byte held
            if (wd[nvm_prog_pkg::CTRL_EPROM_PGM] && st_r.ctrl.eprom_latch_en
                && st_r.ep_have_byte) begin
                st_nxt.ctrl.eprom_prog_en = 1'b1;
            end
            // a written zero leaves program enable alone
            st_nxt.ctrl.eeprom_latch_en = wd[nvm_prog_pkg::CTRL_EE_LAT];
            // erase select only moves before the target address is taken
            if (!st_r.ee_addr_taken && !st_r.ctrl.eeprom_pump_en) begin
                st_nxt.ctrl.eeprom_erase_sel = wd[nvm_prog_pkg::CTRL_EE_ERA];
            end
            // pump needs latched data; a protected target fails instead
            if (wd[nvm_prog_pkg::CTRL_EE_PUMP] && st_r.ctrl.eeprom_latch_en
                && st_r.ee_addr_taken) begin
                if (ee_allowed) begin
                    st_nxt.ctrl.eeprom_pump_en = 1'b1;
                end else begin
                    st_nxt.ee_fail = 1'b1;
                end
            end
        end

        // status write: a one clears a sticky flag
        if (wr_take && (avs_address == nvm_prog_pkg::STAT_ADDR)) begin
            if (wd[nvm_prog_pkg::STAT_EE_FAIL]) begin
                st_nxt.ee_fail = 1'b0;
            end
            if (wd[nvm_prog_pkg::STAT_EP_GROUP_ERR]) begin
                st_nxt.ep_group_err = 1'b0;
            end
        end

        // option byte program: bits only go to zero, and only with the eeprom latch
        if (wr_take && (avs_address == nvm_prog_pkg::OPT_ADDR)
            && st_r.ctrl.eeprom_latch_en) begin
            st_nxt.opt_image[nvm_prog_pkg::OPT_UNPROT] =
                st_r.opt_image[nvm_prog_pkg::OPT_UNPROT] & wd[nvm_prog_pkg::OPT_UNPROT];
            st_nxt.opt_image[nvm_prog_pkg::OPT_SEC_OFF] =
                st_r.opt_image[nvm_prog_pkg::OPT_SEC_OFF] & wd[nvm_prog_pkg::OPT_SEC_OFF];
        end

        // eprom capture window: latch up, program down
        if (mem_wr.wr && in_eprom && st_r.ctrl.eprom_latch_en
            && !st_r.ctrl.eprom_prog_en) begin
            if (!st_r.ep_have_byte || (mem_wr.addr[15:3] == st_r.ep_group)) begin
                st_nxt.ep_have_byte = 1'b1;
                st_nxt.ep_group = mem_wr.addr[15:3];
                st_nxt.ep_mask[mem_wr.addr[2:0]] = 1'b1;
                // the cell only charges towards one, so rewrites merge by or
                st_nxt.ep_data[mem_wr.addr[2:0]] =
                    st_r.ep_data[mem_wr.addr[2:0]] | mem_wr.data;
            end else begin
                st_nxt.ep_group_err = 1'b1;
            end
        end

        // eeprom capture: first write in range takes address and data
        if (mem_wr.wr && in_eeprom && st_r.ctrl.eeprom_latch_en
            && !st_r.ctrl.eeprom_pump_en && !st_r.ee_addr_taken) begin
            st_nxt.ee_addr_taken = 1'b1;
            st_nxt.ee_addr = mem_wr.addr[7:0];
            st_nxt.ee_data = mem_wr.data;
        end

        // latch clear (by software or stop) drops the whole sequence
        if (stop_entry) begin
            st_nxt.ctrl.eprom_latch_en = 1'b0;
            st_nxt.ctrl.eeprom_latch_en = 1'b0;
        end
        if (!st_nxt.ctrl.eprom_latch_en) begin
            st_nxt.ctrl.eprom_prog_en = 1'b0;
            st_nxt.ep_have_byte = 1'b0;
            st_nxt.ep_mask = 8'h00;
            st_nxt.ep_data = '0;
        end
        if (!st_nxt.ctrl.eeprom_latch_en) begin
            st_nxt.ctrl.eeprom_erase_sel = 1'b0;
            st_nxt.ctrl.eeprom_pump_en = 1'b0;
            st_nxt.ee_addr_taken = 1'b0;
        end
        // pump output follows bit; erase select steers the array mode
        st_nxt.ee_pump_out = st_nxt.ctrl.eeprom_pump_en;

        // options are sampled once, the cycle after reset release
        if (!st_r.opts_loaded) begin
            st_nxt.opts_loaded = 1'b1;
            st_nxt.fact_image = factory_opt_in;
            st_nxt.opt_image = option_nv_in;
            // effective protect and security only change across a reset
            st_nxt.unprot_eff = option_nv_in[nvm_prog_pkg::OPT_UNPROT];
            st_nxt.sec_off_eff = option_nv_in[nvm_prog_pkg::OPT_SEC_OFF];
            st_nxt.wdog_en = factory_opt_in[nvm_prog_pkg::FACT_WDOG_RST]
                & ~bootstrap_mode;
        end

        // reset pin hold count after power-on
        if (st_r.opts_loaded && !st_r.por_hold_n) begin
            st_nxt.por_cnt = st_r.por_cnt + 12'h001;
            if (st_r.fact_image[nvm_prog_pkg::FACT_POR_HOLD]) begin
                st_nxt.por_hold_n = (st_nxt.por_cnt >= nvm_prog_pkg::POR_HOLD_SHORT);
            end else begin
                st_nxt.por_hold_n = (st_nxt.por_cnt >= nvm_prog_pkg::POR_HOLD_LONG);
            end
        end

        // watchdog in wait, port pull-downs on input pins only
        st_nxt.wdog_run = st_r.wdog_en & (~wait_mode
            | st_r.fact_image[nvm_prog_pkg::FACT_WDOG_WAIT]);
        st_nxt.portb_pd = {8{st_r.fact_image[nvm_prog_pkg::FACT_PB_PD]}} & ~portb_ddr;
        st_nxt.portc_pd = {8{st_r.fact_image[nvm_prog_pkg::FACT_PC_PD]}} & ~portc_ddr;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // synchronous reset is the power-on or external reset of the block
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.ctrl <= nvm_prog_pkg::CTRL_RESET[5:0];
            st_r.waitreq <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------
    assign avs_readdata = st_r.rdata;
    assign avs_waitrequest = st_r.waitreq;
    // array reads are only valid with the latch down; code must run from ram
    assign eprom_read_ok = ~st_r.ctrl.eprom_latch_en;
    assign eprom_prog_en = st_r.ctrl.eprom_prog_en;
    assign eprom_group_addr = st_r.ep_group;
    assign eprom_byte_mask = st_r.ep_mask;
    assign eprom_group_data = st_r.ep_data;
    assign eeprom_read_ok = ~st_r.ctrl.eeprom_latch_en;
    assign eeprom_erase_sel = st_r.ctrl.eeprom_erase_sel;
    assign eeprom_pump_on = st_r.ee_pump_out;
    assign eeprom_addr = st_r.ee_addr;
    assign eeprom_data = st_r.ee_data;
    assign ext_clock_out_en = st_r.ctrl.ext_clock_out_en;
    assign por_hold_n = st_r.por_hold_n;
    assign wdog_enable = st_r.wdog_en;
    assign wdog_running = st_r.wdog_run;
    assign portb_pulldown = st_r.portb_pd;
    assign portc_pulldown = st_r.portc_pd;
    assign nonuser_mode_ok = st_r.sec_off_eff;

endmodule

/* dv/nvm_prog_ctrl_checker.sv */
// assertion checker for the nonvolatile programming control block
`timescale 1ns/10ps

// ------------------------------------------------------------
// checker on the top module ports
// ------------------------------------------------------------
module nvm_prog_ctrl_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic stop_entry,
    input wire logic wait_mode,
    input wire logic [7:0] factory_opt_in,
    input wire logic [7:0] portb_ddr,
    input wire logic eprom_read_ok,
    input wire logic eprom_prog_en,
    input wire logic eeprom_read_ok,
    input wire logic eeprom_erase_sel,
    input wire logic eeprom_pump_on,
    input wire logic wdog_enable,
    input wire logic wdog_running,
    input wire logic [7:0] portb_pulldown
);
    // one clock domain, so one default clocking and reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one wait cycle");
    chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_prog_latch: assert property (eprom_prog_en |-> !eprom_read_ok)
        else $error("eprom program enable set with latch clear");
    chk_prog_fall: assert property ($fell(eprom_prog_en) |-> eprom_read_ok)
        else $error("eprom program enable cleared while latch still set");
    chk_ee_idle: assert property (eeprom_read_ok |-> !eeprom_erase_sel && !eeprom_pump_on)
        else $error("eeprom erase select or pump set with latch clear");
    chk_pump_hold: assert property ($fell(eeprom_pump_on) |-> eeprom_read_ok)
        else $error("pump released while eeprom latch still set");
    chk_stop_clear: assert property (stop_entry && $past(rst_n)
        |=> eprom_read_ok && eeprom_read_ok && !eprom_prog_en)
        else $error("stop entry did not clear the latches");
    chk_pd_input: assert property ((portb_pulldown & $past(portb_ddr)) == 8'h00)
        else $error("pull-down active on an output pin");
    chk_wdog_wait: assert property (wdog_running
        |-> wdog_enable && (!$past(wait_mode) || factory_opt_in[2]))
        else $error("watchdog running in wait mode without the option");

    // main scenarios reached
    cover property (eprom_prog_en);
    cover property (eeprom_pump_on);
    cover property ($fell(eprom_prog_en));
    cover property (avs_read && !avs_waitrequest);
endmodule

bind nvm_prog_ctrl nvm_prog_ctrl_checker i_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .stop_entry(stop_entry), .wait_mode(wait_mode), .factory_opt_in(factory_opt_in),
    .portb_ddr(portb_ddr), .eprom_read_ok(eprom_read_ok), .eprom_prog_en(eprom_prog_en),
    .eeprom_read_ok(eeprom_read_ok), .eeprom_erase_sel(eeprom_erase_sel),
    .eeprom_pump_on(eeprom_pump_on), .wdog_enable(wdog_enable),
    .wdog_running(wdog_running), .portb_pulldown(portb_pulldown));

/* dv/nvm_prog_ctrl_tb.sv */
// self-checking testbench for the nonvolatile programming control block
`timescale 1ns/10ps

module nvm_prog_ctrl_tb;
    // ------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    nvm_prog_pkg::mem_wr_s mem_wr = '0;
    logic stop_entry = 1'b0;
    logic wait_mode = 1'b0;
    logic [7:0] portb_ddr = 8'h0f;
    logic [7:0] portc_ddr = 8'h00;
    // option inputs change only across a reset, since the design samples them once
    logic [7:0] factory_opt_in = 8'h1a;
    logic [7:0] option_nv_in = 8'h01;
    logic bootstrap_mode = 1'b0;
    logic eprom_read_ok, eprom_prog_en, eeprom_read_ok, eeprom_erase_sel, eeprom_pump_on;
    logic [12:0] eprom_group_addr;
    logic [7:0] eprom_byte_mask, eeprom_addr, eeprom_data, portb_pulldown, portc_pulldown;
    logic [63:0] eprom_group_data;
    logic ext_clock_out_en, por_hold_n, wdog_enable, wdog_running, nonuser_mode_ok;
    int mismatches = 0;
    int comparisons = 0;
    // rows: address, write data, expected readback
    logic [27:0] rows [0:11] = '{
        {nvm_prog_pkg::CTRL_ADDR, 8'hc0, 8'h00},
        {nvm_prog_pkg::CTRL_ADDR, 8'h20, 8'h20},
        {nvm_prog_pkg::CTRL_ADDR, 8'h30, 8'h20},
        {nvm_prog_pkg::CTRL_ADDR, 8'h08, 8'h08},
        {nvm_prog_pkg::CTRL_ADDR, 8'h10, 8'h00},
        {nvm_prog_pkg::CTRL_ADDR, 8'h02, 8'h02},
        {nvm_prog_pkg::CTRL_ADDR, 8'h06, 8'h06},
        {nvm_prog_pkg::CTRL_ADDR, 8'h07, 8'h06},
        {nvm_prog_pkg::CTRL_ADDR, 8'h00, 8'h00},
        {nvm_prog_pkg::FACT_ADDR, 8'h00, 8'h1a},
        {nvm_prog_pkg::OPT_ADDR, 8'h00, 8'h01},
        {12'h800, 8'hff, 8'h00}};

    // options start as short hold, watchdog after reset, port b pull-down; upper eeprom protected
    nvm_prog_ctrl i_dut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .mem_wr, .stop_entry,
        .wait_mode, .bootstrap_mode, .factory_opt_in, .option_nv_in,
        .portb_ddr, .portc_ddr, .eprom_read_ok, .eprom_prog_en, .eprom_group_addr,
        .eprom_byte_mask, .eprom_group_data, .eeprom_read_ok, .eeprom_erase_sel,
        .eeprom_pump_on, .eeprom_addr, .eeprom_data, .ext_clock_out_en, .por_hold_n,
        .wdog_enable, .wdog_running, .portb_pulldown, .portc_pulldown, .nonuser_mode_ok);

    // 250 MHz clock
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one avalon transfer; extra edge after release so the next request never shares a step
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int n = 0;
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        if (n >= 64) begin
            mismatches++;
            stop_test();
        end
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wreg(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(nm, {56'h0, exp}, {56'h0, q});
    endtask

    task automatic mwr(input logic [15:0] a, input logic [7:0] d);
        mem_wr <= '{wr: 1'b1, addr: a, data: d};
        @(posedge sys_clk);
        mem_wr.wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic stop_pulse();
        stop_entry <= 1'b1;
        @(posedge sys_clk);
        stop_entry <= 1'b0;
        @(posedge sys_clk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        chk("por_hold_n", 0, por_hold_n);
        n = 0;
        while (por_hold_n !== 1'b1 && n < 5000) begin
            @(posedge sys_clk);
            n++;
        end
        chk("por_hold_cycles", 1, n >= 15 && n <= 20);
        chk("wdog_enable", 1, wdog_enable);
        chk("portb_pulldown", 8'hf0, portb_pulldown);
        chk("portc_pulldown", 8'h00, portc_pulldown);
        chk("nonuser_mode_ok", 1, nonuser_mode_ok);
        foreach (rows[i]) begin
            wreg(rows[i][27:16], rows[i][15:8]);
            rchk("row_readback", rows[i][27:16], rows[i][7:0]);
        end
        // eprom group: or-ing into a byte, foreign group refused
        wreg(nvm_prog_pkg::CTRL_ADDR, 8'h20);
        mwr(16'h0400, 8'h01);
        mwr(16'h0400, 8'h10);
        mwr(16'h0407, 8'ha5);
        mwr(16'h0408, 8'hff);
        chk("eprom_group_addr", 13'h0080, eprom_group_addr);
        chk("eprom_byte_mask", 8'h81, eprom_byte_mask);
        chk("eprom_group_data", {8'ha5, 48'h0, 8'h11}, eprom_group_data);
        rchk("status", nvm_prog_pkg::STAT_ADDR, 8'h02);
        wreg(nvm_prog_pkg::CTRL_ADDR, 8'h30);
        chk("eprom_prog_en", 1, eprom_prog_en);
        chk("eprom_read_ok", 0, eprom_read_ok);
        wreg(nvm_prog_pkg::CTRL_ADDR, 8'h20);
        chk("eprom_prog_en", 1, eprom_prog_en);
        wreg(nvm_prog_pkg::STAT_ADDR, 8'h03);
        stop_pulse();
        chk("eprom_prog_en", 0, eprom_prog_en);
        chk("eprom_read_ok", 1, eprom_read_ok);
        rchk("control", nvm_prog_pkg::CTRL_ADDR, 8'h00);
        // eeprom erase of a protected byte is refused
        wreg(nvm_prog_pkg::CTRL_ADDR, 8'h02);
        wreg(nvm_prog_pkg::CTRL_ADDR, 8'h06);
        mwr(16'h0125, 8'h5a);
        wreg(nvm_prog_pkg::CTRL_ADDR, 8'h02);
        chk("eeprom_erase_sel", 1, eeprom_erase_sel);
        wreg(nvm_prog_pkg::CTRL_ADDR, 8'h07);
        chk("eeprom_pump_on", 0, eeprom_pump_on);
        rchk("status", nvm_prog_pkg::STAT_ADDR, 8'h01);
        wreg(nvm_prog_pkg::STAT_ADDR, 8'h03);
        wreg(nvm_prog_pkg::CTRL_ADDR, 8'h00);
        chk("eeprom_erase_sel", 0, eeprom_erase_sel);
        // eeprom programming in the always-writable lower part
        wreg(nvm_prog_pkg::CTRL_ADDR, 8'h02);
        mwr(16'h0110, 8'h3c);
        wreg(nvm_prog_pkg::CTRL_ADDR, 8'h03);
        chk("eeprom_target", 16'h103c, {eeprom_addr, eeprom_data});
        wreg(nvm_prog_pkg::CTRL_ADDR, 8'h02);
        rchk("control", nvm_prog_pkg::CTRL_ADDR, 8'h03);
        wreg(nvm_prog_pkg::OPT_ADDR, 8'h00);
        rchk("option", nvm_prog_pkg::OPT_ADDR, 8'h00);
        chk("nonuser_mode_ok", 1, nonuser_mode_ok);
        stop_pulse();
        chk("eeprom_idle", 2'b10, {eeprom_read_ok, eeprom_pump_on});
        // watchdog in wait mode and pull-downs following direction
        wait_mode <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("wdog_running", 0, wdog_running);
        wait_mode <= 1'b0;
        portb_ddr <= 8'hf0;
        repeat (3) @(posedge sys_clk);
        chk("wdog_running", 1, wdog_running);
        chk("portb_pulldown", 8'h0f, portb_pulldown);
        // mid-run reset: long hold, wait-mode watchdog, port c pull-down, secured part
        wreg(nvm_prog_pkg::CTRL_ADDR, 8'h2a);
        chk("ext_clock_out_en", 1, ext_clock_out_en);
        chk("latches_set", 2'b00, {eprom_read_ok, eeprom_read_ok});
        factory_opt_in <= 8'h0d;
        option_nv_in <= 8'h00;
        rst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        n = 0;
        while (por_hold_n !== 1'b1 && n < 5000) begin
            @(posedge sys_clk);
            n++;
        end
        chk("por_hold_long", 1, n >= nvm_prog_pkg::POR_HOLD_LONG
            && n <= nvm_prog_pkg::POR_HOLD_LONG + 12'h006);
        rchk("control", nvm_prog_pkg::CTRL_ADDR, 8'h00);
        chk("wdog_enable", 1, wdog_enable);
        chk("portc_pulldown", 8'hff, portc_pulldown);
        chk("portb_pulldown", 8'h00, portb_pulldown);
        chk("nonuser_mode_ok", 0, nonuser_mode_ok);
        wait_mode <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("wdog_running", 1, wdog_running);
        wait_mode <= 1'b0;
        // bootstrap lifts the upper eeprom protection
        bootstrap_mode <= 1'b1;
        wreg(nvm_prog_pkg::CTRL_ADDR, 8'h02);
        mwr(16'h01f0, 8'h77);
        wreg(nvm_prog_pkg::CTRL_ADDR, 8'h03);
        chk("eeprom_pump_on", 1, eeprom_pump_on);
        // software ends the operation by dropping the latch
        wreg(nvm_prog_pkg::CTRL_ADDR, 8'h00);
        chk("eeprom_pump_on", 0, eeprom_pump_on);
        stop_test();
    end
endmodule
